// ---- scan_regs_cfg.svh ----
// Constants for the boundary scan test data registers.
`ifndef SCAN_REGS_CFG_SVH
`define SCAN_REGS_CFG_SVH
`define IR_LEN 3
`define BSR_LEN 68
`define ID_LEN 32
`define IR_EXTEST 3'h0
`define IR_IDCODE 3'h1
`define IR_SAMPLE 3'h2
`define IR_CLAMP 3'h3
`define IR_HIGHZ 3'h4
`define IR_BYPASS 3'h7
`define IR_CAPTURE 3'h1
// Identification fields; the version, part and maker values are arbitrary.
`define ID_VERSION 4'h0
`define ID_PART 16'h0000
`define ID_MAKER 11'h000
`define ID_FIXED 1'h1
`define CELL_DATABUS_DIR 54
`define CELL_IRQ_DIR 39
`define CELL_DATA_LO 46
`define CELL_IRQ 38
`endif

// ---- scan_regs_pkg.sv ----
// Types for the boundary scan test data registers.
package scan_regs_pkg;
    typedef enum logic [3:0] {
        TLR = 4'h0, RTI = 4'h1, SEL_DR = 4'h2, CAP_DR = 4'h3,
        SH_DR = 4'h4, EX1_DR = 4'h5, PA_DR = 4'h6, EX2_DR = 4'h7,
        UPD_DR = 4'h8, SEL_IR = 4'h9, CAP_IR = 4'hA, SH_IR = 4'hB,
        EX1_IR = 4'hC, PA_IR = 4'hD, EX2_IR = 4'hE, UPD_IR = 4'hF
    } tap_state_t;
endpackage : scan_regs_pkg

// ---- scan_regs.sv ----
// Test data registers behind the boundary scan port, with a minimal port controller.
`include "scan_regs_cfg.svh"

// Behaviour
// - A one-bit bypass stage is the scan path under bypass, clamp and highz.
// - Bypass, boundary scan and identification registers are all provided.
// - The identification register has a 32-bit shift stage and a 32-bit latched output.
// - The identification register is selected under idcode and in test-logic-reset.
// - The boundary register shifts and latches every digital I/O and control cell.
// - Cell 54 sets the shared data/address pins to input on 0 and output on 1.
// - Cell 39 sets the interrupt pin to input on 0 and output on 1.
// - The identification value is version, part, maker, then a fixed one at bit 0.
// - The identification value is loaded on the edge leaving capture-DR and shifted out.
// - The instruction register is three bits, latched on the falling edge in update-IR.
// - Under highz every digital output floats while bypass is the scan path.
module scan_regs (
    input wire logic clock, // System clock, 10 MHz.
    input wire logic rst, // Synchronous reset, active high.
    input wire logic scan_clock, // Test clock pin.
    input wire logic scan_mode_select, // Test mode select pin.
    input wire logic scan_data_in, // Test data input pin.
    input wire logic scan_reset_n, // Test reset pin, active low.
    input wire logic [`BSR_LEN-1:0] pin_sample, // Levels captured from the pin cells.
    output logic scan_data_out, // Test data output.
    output logic scan_data_out_oe, // Test data output enable.
    output logic [`BSR_LEN-1:0] bsr_latch, // Boundary latched parallel output.
    output logic [`ID_LEN-1:0] id_latch, // Identification latched output.
    output logic [`IR_LEN-1:0] instr, // Current instruction.
    output logic test_drive, // Pins take values from the boundary latch.
    output logic outputs_float, // All digital outputs high impedance.
    output logic shared_data_addr_pins_oe, // Shared data/address pins drive.
    output logic irq_pin_oe // Interrupt pin drives.
);
    localparam logic [`ID_LEN-1:0] ID_VALUE = {`ID_VERSION, `ID_PART, `ID_MAKER, `ID_FIXED};
    logic [2:0] tck_s, tms_s, tdi_s, trst_s;
    scan_regs_pkg::tap_state_t state;
    scan_regs_pkg::tap_state_t next_state;
    logic [`IR_LEN-1:0] ir_shift;
    logic bypass_bit;
    logic [`ID_LEN-1:0] id_shift;
    logic [`BSR_LEN-1:0] bsr_shift;
    logic rise, fall, tms, tdi, trst;
    logic sel_id, sel_bsr;
    logic [`BSR_LEN-1:0] pin_meta, pin_sync;

    // Two-flop synchronisers with a third stage for edge detection.
    always_ff @(posedge clock) begin
        tck_s <= {tck_s[1:0], scan_clock};
        tms_s <= {tms_s[1:0], scan_mode_select};
        tdi_s <= {tdi_s[1:0], scan_data_in};
        trst_s <= {trst_s[1:0], ~scan_reset_n};
    end
    assign rise = tck_s[1] & ~tck_s[2];
    assign fall = ~tck_s[1] & tck_s[2];
    assign tms = tms_s[1];
    assign tdi = tdi_s[1];
    assign trst = trst_s[1];

    // Pin cell levels pass two flip-flops before the capture stage reads them.
    always_ff @(posedge clock) begin
        pin_meta <= pin_sample;
        pin_sync <= pin_meta;
    end

    // Register selection from the current instruction and controller state.
    assign sel_id = (instr == `IR_IDCODE) || (state == scan_regs_pkg::TLR);
    assign sel_bsr = (instr == `IR_EXTEST) || (instr == `IR_SAMPLE);

    // Next controller state from the mode select level.
    always_comb begin
        unique case (state)
            scan_regs_pkg::TLR: next_state = tms ? scan_regs_pkg::TLR : scan_regs_pkg::RTI;
            scan_regs_pkg::RTI: next_state = tms ? scan_regs_pkg::SEL_DR : scan_regs_pkg::RTI;
            scan_regs_pkg::SEL_DR:
                next_state = tms ? scan_regs_pkg::SEL_IR : scan_regs_pkg::CAP_DR;
            scan_regs_pkg::CAP_DR: next_state = tms ? scan_regs_pkg::EX1_DR : scan_regs_pkg::SH_DR;
            scan_regs_pkg::SH_DR: next_state = tms ? scan_regs_pkg::EX1_DR : scan_regs_pkg::SH_DR;
            scan_regs_pkg::EX1_DR: next_state = tms ? scan_regs_pkg::UPD_DR : scan_regs_pkg::PA_DR;
            scan_regs_pkg::PA_DR: next_state = tms ? scan_regs_pkg::EX2_DR : scan_regs_pkg::PA_DR;
            scan_regs_pkg::EX2_DR: next_state = tms ? scan_regs_pkg::UPD_DR : scan_regs_pkg::SH_DR;
            scan_regs_pkg::UPD_DR: next_state = tms ? scan_regs_pkg::SEL_DR : scan_regs_pkg::RTI;
            scan_regs_pkg::SEL_IR: next_state = tms ? scan_regs_pkg::TLR : scan_regs_pkg::CAP_IR;
            scan_regs_pkg::CAP_IR: next_state = tms ? scan_regs_pkg::EX1_IR : scan_regs_pkg::SH_IR;
            scan_regs_pkg::SH_IR: next_state = tms ? scan_regs_pkg::EX1_IR : scan_regs_pkg::SH_IR;
            scan_regs_pkg::EX1_IR: next_state = tms ? scan_regs_pkg::UPD_IR : scan_regs_pkg::PA_IR;
            scan_regs_pkg::PA_IR: next_state = tms ? scan_regs_pkg::EX2_IR : scan_regs_pkg::PA_IR;
            scan_regs_pkg::EX2_IR: next_state = tms ? scan_regs_pkg::UPD_IR : scan_regs_pkg::SH_IR;
            scan_regs_pkg::UPD_IR: next_state = tms ? scan_regs_pkg::SEL_DR : scan_regs_pkg::RTI;
        endcase
    end

    // Controller state advances on each rising test clock edge.
    always_ff @(posedge clock) begin
        if (rst || trst) begin
            state <= scan_regs_pkg::TLR;
        end else if (rise) begin
            state <= next_state;
        end
    end

    // Instruction shift stage and latch; the latch loads on the falling edge in update-IR.
    always_ff @(posedge clock) begin
        if (rst || trst || state == scan_regs_pkg::TLR) begin
            ir_shift <= `IR_CAPTURE;
            instr <= `IR_IDCODE;
        end else begin
            if (rise && state == scan_regs_pkg::CAP_IR) begin
                ir_shift <= `IR_CAPTURE;
            end else if (rise && state == scan_regs_pkg::SH_IR) begin
                ir_shift <= {tdi, ir_shift[`IR_LEN-1:1]};
            end
            if (fall && state == scan_regs_pkg::UPD_IR) begin
                instr <= ir_shift;
            end
        end
    end

    // Data register shift stages: capture, then shift toward bit 0.
    always_ff @(posedge clock) begin
        if (rst) begin
            bypass_bit <= 1'h0;
            id_shift <= '0;
            bsr_shift <= '0;
        end else if (rise && state == scan_regs_pkg::CAP_DR) begin
            bypass_bit <= 1'h0;
            if (sel_id) begin
                id_shift <= ID_VALUE;
            end
            if (sel_bsr) begin
                bsr_shift <= pin_sync;
            end
        end else if (rise && state == scan_regs_pkg::SH_DR) begin
            if (sel_id) begin
                id_shift <= {tdi, id_shift[`ID_LEN-1:1]};
            end else if (sel_bsr) begin
                bsr_shift <= {tdi, bsr_shift[`BSR_LEN-1:1]};
            end else begin
                bypass_bit <= tdi;
            end
        end
    end

    // Parallel latches load on the falling edge in update-DR.
    always_ff @(posedge clock) begin
        if (rst) begin
            bsr_latch <= '0;
            id_latch <= ID_VALUE;
        end else if (fall && state == scan_regs_pkg::UPD_DR) begin
            if (sel_bsr) begin
                bsr_latch <= bsr_shift;
            end
            if (sel_id) begin
                id_latch <= id_shift;
            end
        end
    end

    // Serial output changes on the falling edge from the active path.
    always_ff @(posedge clock) begin
        if (rst) begin
            scan_data_out <= 1'h0;
            scan_data_out_oe <= 1'h0;
        end else if (fall) begin
            scan_data_out_oe <= (state == scan_regs_pkg::SH_DR) || (state == scan_regs_pkg::SH_IR);
            if (state == scan_regs_pkg::SH_IR) begin
                scan_data_out <= ir_shift[0];
            end else if (sel_id) begin
                scan_data_out <= id_shift[0];
            end else if (sel_bsr) begin
                scan_data_out <= bsr_shift[0];
            end else begin
                scan_data_out <= bypass_bit;
            end
        end
    end

    // Pin control derived from the current instruction and the direction cells.
    always_ff @(posedge clock) begin
        if (rst) begin
            test_drive <= 1'h0;
            outputs_float <= 1'h0;
            shared_data_addr_pins_oe <= 1'h0;
            irq_pin_oe <= 1'h0;
        end else begin
            test_drive <= (instr == `IR_EXTEST) || (instr == `IR_CLAMP);
            outputs_float <= (instr == `IR_HIGHZ);
            shared_data_addr_pins_oe <= (instr != `IR_HIGHZ) &&
                bsr_latch[`CELL_DATABUS_DIR];
            irq_pin_oe <= (instr != `IR_HIGHZ) && bsr_latch[`CELL_IRQ_DIR];
        end
    end

    // Assertions.
    property p_float;
        @(posedge clock) disable iff (rst) instr == `IR_HIGHZ |=> outputs_float;
    endproperty
    a_float: assert property (p_float) else $error("highz did not float outputs");
    property p_idsel;
        @(posedge clock) disable iff (rst)
            fall && state == scan_regs_pkg::SH_DR && instr == `IR_IDCODE |=>
                scan_data_out == $past(id_shift[0]);
    endproperty
    a_idsel: assert property (p_idsel) else $error("idcode did not drive the output");
    property p_tlrinstr;
        @(posedge clock) disable iff (rst) state == scan_regs_pkg::TLR |=> instr == `IR_IDCODE;
    endproperty
    a_tlrinstr: assert property (p_tlrinstr) else $error("idcode not forced");
    property p_idcap;
        @(posedge clock) disable iff (rst || trst)
            rise && state == scan_regs_pkg::CAP_DR && sel_id |=> id_shift == ID_VALUE;
    endproperty
    a_idcap: assert property (p_idcap) else $error("id value not captured");
    property p_idlsb;
        @(posedge clock) disable iff (rst)
            rise && state == scan_regs_pkg::CAP_DR && instr == `IR_IDCODE |=> id_shift[0];
    endproperty
    a_idlsb: assert property (p_idlsb) else $error("id lsb not one");
    property p_busdir;
        @(posedge clock) disable iff (rst)
            instr != `IR_HIGHZ && $stable(instr) |=>
                shared_data_addr_pins_oe == $past(bsr_latch[`CELL_DATABUS_DIR]);
    endproperty
    a_busdir: assert property (p_busdir) else $error("bus direction wrong");
    property p_irqdir;
        @(posedge clock) disable iff (rst)
            instr != `IR_HIGHZ && $stable(instr) |=>
                irq_pin_oe == $past(bsr_latch[`CELL_IRQ_DIR]);
    endproperty
    a_irqdir: assert property (p_irqdir) else $error("irq direction wrong");
    property p_byp;
        @(posedge clock) disable iff (rst)
            fall && state == scan_regs_pkg::SH_DR && !sel_id && !sel_bsr |=>
                scan_data_out == $past(bypass_bit);
    endproperty
    a_byp: assert property (p_byp) else $error("bypass path wrong");
    property p_bsr0;
        @(posedge clock) disable iff (rst)
            fall && state == scan_regs_pkg::SH_DR && sel_bsr && !sel_id |=>
                scan_data_out == $past(bsr_shift[0]);
    endproperty
    a_bsr0: assert property (p_bsr0) else $error("cell 0 not first out");
    property p_irupd;
        @(posedge clock) disable iff (rst || trst)
            fall && state == scan_regs_pkg::UPD_IR |=> instr == $past(ir_shift);
    endproperty
    a_irupd: assert property (p_irupd) else $error("instruction not latched");
endmodule : scan_regs

// ---- scan_tester.sv ----
// Board tester model that drives the scan port pins.
module scan_tester (
    input wire logic clock, // System clock that paces the scan clock.
    input wire logic scan_data_out, // Serial data from the device.
    input wire logic scan_data_out_oe, // Output enable from the device.
    output logic scan_clock, // Scan clock, still between frames.
    output logic scan_mode_select, // Mode select.
    output logic scan_data_in // Serial data into the device.
);
    timeunit 1ns;
    timeprecision 1ns;
    logic seen;

    // Pins idle with the clock low.
    initial begin
        scan_clock = 1'h0;
        scan_mode_select = 1'h1;
        scan_data_in = 1'h0;
    end

    // One 800 ns period: data set a clock ahead, high 300 ns, output sampled late in the low.
    task automatic tick(input logic tms, input logic tdi);
        scan_mode_select = tms;
        scan_data_in = tdi;
        @(posedge clock);
        #1;
        scan_clock = 1'h1;
        repeat (3) @(posedge clock);
        #1;
        scan_clock = 1'h0;
        repeat (4) @(posedge clock);
        #1;
        seen = scan_data_out_oe ? scan_data_out : 1'h1; // A released output reads as pulled up.
    endtask : tick

    // Five highs reach test-logic-reset whatever the state, then a low idles.
    task automatic reset_tap();
        repeat (5) tick(1'h1, 1'h0);
        tick(1'h0, 1'h0);
    endtask : reset_tap

    // Full data or instruction scan from idle, bit 0 in and out first, back to idle.
    task automatic scan(input logic ir, input int n, input logic [67:0] din,
                        output logic [67:0] dout);
        dout = '0;
        tick(1'h1, 1'h0);
        if (ir) tick(1'h1, 1'h0);
        tick(1'h0, 1'h0);
        tick(1'h0, 1'h0);
        dout[0] = seen;
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, din[i]);
            if (i < n - 1) dout[i + 1] = seen;
        end
        tick(1'h1, 1'h0);
        tick(1'h0, 1'h0);
    endtask : scan
endmodule : scan_tester

// ---- tb_top.sv ----
// Self-checking bench for the boundary scan test data registers.
`include "scan_regs_cfg.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] ID_EXP = {`ID_VERSION, `ID_PART, `ID_MAKER, `ID_FIXED};
    localparam logic [8:0] BP_CODES = {`IR_HIGHZ, `IR_CLAMP, `IR_BYPASS};
    logic clock = 1'h0;
    logic rst, scan_reset_n;
    logic [`BSR_LEN-1:0] pin_sample, bsr_latch;
    logic [`ID_LEN-1:0] id_latch;
    logic [`IR_LEN-1:0] instr;
    logic scan_clock, scan_mode_select, scan_data_in, scan_data_out, scan_data_out_oe;
    logic test_drive, outputs_float, shared_data_addr_pins_oe, irq_pin_oe;
    int num_errors = 0;
    int tests_run = 0;

    // Clock of 100 ns period.
    always #50 clock = ~clock;

    scan_regs scan_regs_inst (.clock(clock), .rst(rst), .scan_clock(scan_clock),
        .scan_mode_select(scan_mode_select), .scan_data_in(scan_data_in),
        .scan_reset_n(scan_reset_n), .pin_sample(pin_sample), .scan_data_out(scan_data_out),
        .scan_data_out_oe(scan_data_out_oe), .bsr_latch(bsr_latch), .id_latch(id_latch),
        .instr(instr), .test_drive(test_drive), .outputs_float(outputs_float),
        .shared_data_addr_pins_oe(shared_data_addr_pins_oe), .irq_pin_oe(irq_pin_oe));
    scan_tester scan_tester_inst (.clock(clock), .scan_data_out(scan_data_out),
        .scan_data_out_oe(scan_data_out_oe),
        .scan_clock(scan_clock), .scan_mode_select(scan_mode_select),
        .scan_data_in(scan_data_in));

    // Compares a vector result.
    task automatic check_vec(input string name, input logic [67:0] exp, input logic [67:0] got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : check_vec

    // Prints the counts and the verdict, then ends the run.
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish

    // Works out whether an instruction hands the pins to the boundary latch.
    function automatic logic exp_drive(input logic [2:0] c);
        return (c == `IR_EXTEST) || (c == `IR_CLAMP);
    endfunction : exp_drive

    // Loads an instruction and checks the captured code and the latched result.
    task automatic load_ir(input logic [2:0] c);
        logic [67:0] q;
        scan_tester_inst.scan(1'h1, 3, {65'h0, c}, q);
        check_vec("ir_capture", `IR_CAPTURE, q[2:0]);
        check_vec("instr", c, instr);
        check_vec("test_drive", exp_drive(c), test_drive);
        check_vec("oe_idle", 1'h0, scan_data_out_oe);
    endtask : load_ir

    // Cuts a hung run short.
    initial begin
        repeat (100000) @(posedge clock);
        num_errors++;
        tally_and_finish();
    end

    // Main sequence.
    initial begin
        logic [67:0] d, q;
        logic [2:0] c;
        rst = 1'h1;
        scan_reset_n = 1'h1;
        pin_sample = '0;
        void'($urandom(95440));
        repeat (16) @(posedge clock);
        #1 rst = 1'h0;
        @(posedge clock);
        #1;
        check_vec("instr_rst", `IR_IDCODE, instr);
        check_vec("id_latch", ID_EXP, id_latch);
        scan_tester_inst.reset_tap();
        d = 68'($urandom());
        scan_tester_inst.scan(1'h0, 32, d, q);
        check_vec("id_shift", ID_EXP, q[31:0]);
        check_vec("id_latch_upd", d[31:0], id_latch);
        $display("test idcode done");
        for (int k = 0; k < 3; k++) begin
            c = BP_CODES[3 * k +: 3];
            load_ir(c);
            d = 68'($urandom());
            scan_tester_inst.scan(1'h0, 16, d, q);
            check_vec("bypass", {d[14:0], 1'h0}, q[15:0]);
            check_vec("float", c == `IR_HIGHZ, outputs_float);
            if (c == `IR_HIGHZ) begin
                check_vec("bus_oe", 1'h0, shared_data_addr_pins_oe);
            end
        end
        $display("test bypass done");
        for (int k = 0; k < 4; k++) begin
            c = (k < 2) ? `IR_SAMPLE : `IR_EXTEST;
            load_ir(c);
            pin_sample = 68'({$urandom(), $urandom(), $urandom()});
            d = 68'({$urandom(), $urandom(), $urandom()});
            d[`CELL_DATABUS_DIR] = k[0];
            d[`CELL_IRQ_DIR] = ~k[0];
            scan_tester_inst.scan(1'h0, 68, d, q);
            check_vec("bsr_shift", pin_sample, q);
            check_vec("bsr_latch", d, bsr_latch);
            if (c == `IR_EXTEST) begin
                check_vec("bus_oe", d[`CELL_DATABUS_DIR], shared_data_addr_pins_oe);
                check_vec("irq_oe", d[`CELL_IRQ_DIR], irq_pin_oe);
            end
        end
        $display("test boundary done");
        scan_reset_n = 1'h0;
        repeat (5) @(posedge clock);
        #1 scan_reset_n = 1'h1;
        repeat (2) @(posedge clock);
        #1;
        check_vec("instr_trst", `IR_IDCODE, instr);
        scan_tester_inst.tick(1'h0, 1'h0);
        scan_tester_inst.scan(1'h0, 32, '0, q);
        check_vec("id_again", ID_EXP, q[31:0]);
        $display("test test_reset done");
        tally_and_finish();
    end
endmodule : tb_top
